// File: rtl/sfep_defines.vh
// What this block does
// - small_region_wipe (20h) runs only when write_permit_latch is set.
// - small_region_wipe picks the 4K sector from address bits 23..12.
// - wipe frames must deselect exactly on a byte boundary, else rejected.
// - wipe frame is opcode plus three address bytes on lane 0 only.
// - valid wipe starts on deselect; busy_flag high; then idle, latch clear.
// - wipes set cells to one; protected sectors are never wiped.
// - half_region_wipe (52h) wipes the 32K block holding the address.
// - protected half_region_wipe leaves data alone but clears the latch.
// - mid_region_wipe (d8h) wipes the 64K block unless it is protected.
// - whole_array_wipe is 60h or c7h with no address bytes.
// - whole_array_wipe runs only when nothing is protected.
// - page_write (02h) programs zeros and needs write_permit_latch.
// - data past the page end wraps to offset zero of the same page.
// - over 256 data bytes: only the last 256 are programmed.
// - under 256 bytes: program from start offset, leave others untouched.
// - page_write needs at least one data byte and a byte-aligned deselect.
// - valid page_write runs timed program cycle; protected pages skipped.
// - four_lane_page_write (32h) needs the latch and four_lane_allow.
// - in 32h opcode and address use lane 0, data uses all four lanes.
// - half wipe keeps busy_flag high while running; status stays readable.
`ifndef SFEP_DEFINES_VH
`define SFEP_DEFINES_VH

// ****************************************************************
// opcodes
// ****************************************************************
`define SFEP_OPC_PERMIT 8'h06
`define SFEP_OPC_SMALL 8'h20
`define SFEP_OPC_HALF 8'h52
`define SFEP_OPC_MID 8'hd8
`define SFEP_OPC_WHOLE_A 8'h60
`define SFEP_OPC_WHOLE_B 8'hc7
`define SFEP_OPC_PAGE 8'h02
`define SFEP_OPC_QPAGE 8'h32

// ****************************************************************
// frame and array layout
// ****************************************************************
`define SFEP_WIPE_BYTES 4'h4
`define SFEP_CMD_BYTES 4'h1
`define SFEP_PAGE_MIN_BYTES 4'h5
`define SFEP_ADDR_W 24
`define SFEP_SMALL_MASK 24'hfff000
`define SFEP_HALF_MASK 24'hff8000
`define SFEP_MID_MASK 24'hff0000
`define SFEP_KIND_SMALL 2'h0
`define SFEP_KIND_HALF 2'h1
`define SFEP_KIND_MID 2'h2
`define SFEP_KIND_WHOLE 2'h3

// ****************************************************************
// timing (self-timed cycles, microseconds)
// ****************************************************************
`define SFEP_CLK_MHZ 200
`define SFEP_SMALL_WIPE_TIME_US 100
`define SFEP_HALF_WIPE_TIME_US 200
`define SFEP_MID_WIPE_TIME_US 300
`define SFEP_WHOLE_WIPE_TIME_US 1000
`define SFEP_PAGE_WRITE_TIME_US 50

// ****************************************************************
// program buffer
// ****************************************************************
`define SFEP_FIFO_W 16
`define SFEP_FIFO_D 16
`define SFEP_FIFO_AW 4

`endif

// File: rtl/sfep_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sfep_defines.vh"

// ****************************************************************
// program stream fifo
// ****************************************************************
module sfep_fifo #(
  parameter W = 16,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0] cnt_r;
  reg [AW:0] cnt_nxt;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign out_data = mem[rd_ptr_r];

  always @* begin
    cnt_nxt = cnt_r;
    if (push & ~pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop & ~push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != D[AW:0]);
      out_valid <= (cnt_nxt != {(AW+1){1'b0}});
    end
  end
endmodule

// ****************************************************************
// erase / program command sequencer
// ****************************************************************
module sfep_top #(
  parameter [31:0] SMALL_WIPE_CYC = `SFEP_SMALL_WIPE_TIME_US * `SFEP_CLK_MHZ,
  parameter [31:0] HALF_WIPE_CYC = `SFEP_HALF_WIPE_TIME_US * `SFEP_CLK_MHZ,
  parameter [31:0] MID_WIPE_CYC = `SFEP_MID_WIPE_TIME_US * `SFEP_CLK_MHZ,
  parameter [31:0] WHOLE_WIPE_CYC = `SFEP_WHOLE_WIPE_TIME_US * `SFEP_CLK_MHZ,
  parameter [31:0] PAGE_WRITE_CYC = `SFEP_PAGE_WRITE_TIME_US * `SFEP_CLK_MHZ
) (
  input wire clk,
  input wire sys_rst,
  input wire chip_select_n,
  input wire serial_clk,
  input wire [3:0] io_lane_in,
  input wire [4:0] protect_range_bits,
  input wire four_lane_allow,
  input wire prog_ready,
  output reg busy_flag,
  output reg write_permit_latch,
  output reg wipe_req,
  output reg [1:0] wipe_kind,
  output reg [23:0] wipe_addr,
  output wire prog_valid,
  output wire [23:0] prog_addr,
  output wire [7:0] prog_data,
  output reg cmd_reject
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WIPE = 2'h1;
  localparam ST_PUSH = 2'h2;
  localparam ST_PROG = 2'h3;

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  reg cs_s1_r, cs_s2_r, cs_d3_r;
  reg sclk_s1_r, sclk_s2_r, sclk_d3_r;
  reg [3:0] io_s1_r, io_s2_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d3_r <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_d3_r <= 1'b0;
      io_s1_r <= 4'h0;
      io_s2_r <= 4'h0;
    end else begin
      cs_s1_r <= chip_select_n;
      cs_s2_r <= cs_s1_r;
      cs_d3_r <= cs_s2_r;
      sclk_s1_r <= serial_clk;
      sclk_s2_r <= sclk_s1_r;
      sclk_d3_r <= sclk_s2_r;
      io_s1_r <= io_lane_in;
      io_s2_r <= io_s1_r;
    end
  end

  wire cs_fall = cs_d3_r & ~cs_s2_r;
  wire cs_rise = ~cs_d3_r & cs_s2_r;
  // idle-high clock (mode 3) gives no edge at select, only true rises count
  wire sclk_rise = sclk_s2_r & ~sclk_d3_r & ~cs_s2_r;

  // ****************************************************************
  // frame shifter
  // ****************************************************************
  reg [7:0] shift_r;
  reg [3:0] bit_cnt_r;
  reg [3:0] byte_cnt_r;
  reg [7:0] opc_r;
  reg [23:0] addr_r;
  reg [7:0] page_off_r;
  reg frame_dirty_r;
  reg [7:0] pbuf [0:255];
  reg [255:0] pvld_r;

  wire is_page = (opc_r == `SFEP_OPC_PAGE) | (opc_r == `SFEP_OPC_QPAGE);
  // opcode and address on lane 0, data of 32h on all lanes
  wire quad_phase = (opc_r == `SFEP_OPC_QPAGE) &
    (byte_cnt_r >= `SFEP_WIPE_BYTES);
  wire [3:0] step = quad_phase ? 4'h4 : 4'h1;
  // upper lanes ignored outside the four-lane data phase
  wire [7:0] byte_w = quad_phase ? {shift_r[3:0], io_s2_r} :
    {shift_r[6:0], io_s2_r[0]};
  wire byte_done = sclk_rise & ((bit_cnt_r + step) == 4'h8);

  // ****************************************************************
  // sequencer state
  // ****************************************************************
  reg [1:0] st_r;
  reg [31:0] tmr_r;
  reg [8:0] walk_r;
  reg [23:0] page_base_r;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire [15:0] fifo_out_data;
  wire [7:0] prot_n = (protect_range_bits[2:0] == 3'h0) ? 8'h00 :
    (8'h01 << (protect_range_bits[2:0] - 3'h1));
  wire [6:0] prot_blk = protect_range_bits[3] ? addr_r[22:16] :
    ~addr_r[22:16];
  wire hit = ({1'b0, prot_blk} < prot_n);
  wire aligned = (bit_cnt_r == 4'h0) & ~frame_dirty_r;
  wire permit_ok = write_permit_latch;

  always @(posedge clk) begin
    if (byte_done & (byte_cnt_r >= `SFEP_WIPE_BYTES) & is_page &
        (st_r == ST_IDLE)) begin
      pbuf[page_off_r] <= byte_w;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      byte_cnt_r <= 4'h0;
      opc_r <= 8'h00;
      addr_r <= 24'h000000;
      page_off_r <= 8'h00;
      frame_dirty_r <= 1'b0;
      pvld_r <= 256'h0;
      st_r <= ST_IDLE;
      tmr_r <= 32'h00000000;
      walk_r <= 9'h000;
      page_base_r <= 24'h000000;
      busy_flag <= 1'b0;
      write_permit_latch <= 1'b0;
      wipe_req <= 1'b0;
      wipe_kind <= `SFEP_KIND_SMALL;
      wipe_addr <= 24'h000000;
      cmd_reject <= 1'b0;
    end else begin
      wipe_req <= 1'b0;
      cmd_reject <= 1'b0;
      // frames seen while busy never execute, even if busy ends mid-frame
      if (st_r != ST_IDLE & ~cs_s2_r) begin
        frame_dirty_r <= 1'b1;
      end
      if (cs_fall) begin
        bit_cnt_r <= 4'h0;
        byte_cnt_r <= 4'h0;
        frame_dirty_r <= (st_r != ST_IDLE);
      end else if (sclk_rise) begin
        shift_r <= byte_w;
        if (byte_done) begin
          bit_cnt_r <= 4'h0;
          if (byte_cnt_r != 4'hf) begin
            byte_cnt_r <= byte_cnt_r + 4'h1;
          end
          if (byte_cnt_r == 4'h0) begin
            opc_r <= byte_w;
            if (st_r == ST_IDLE) begin
              pvld_r <= 256'h0;
            end
          end else if (byte_cnt_r < `SFEP_WIPE_BYTES) begin
            addr_r <= {addr_r[15:0], byte_w};
            page_off_r <= byte_w;
          end else if (is_page & (st_r == ST_IDLE)) begin
            // offset wraps inside the page; later bytes overwrite earlier
            pvld_r[page_off_r] <= 1'b1;
            page_off_r <= page_off_r + 8'h01;
          end
        end else begin
          bit_cnt_r <= bit_cnt_r + step;
        end
      end

      case (st_r)
        ST_IDLE: begin
          if (cs_rise & ~frame_dirty_r) begin
            case (opc_r)
              `SFEP_OPC_PERMIT: begin
                if (aligned & (byte_cnt_r == `SFEP_CMD_BYTES)) begin
                  write_permit_latch <= 1'b1;
                end else begin
                  cmd_reject <= 1'b1;
                end
              end
              `SFEP_OPC_SMALL, `SFEP_OPC_HALF, `SFEP_OPC_MID: begin
                if (!aligned || byte_cnt_r != `SFEP_WIPE_BYTES ||
                    !permit_ok) begin
                  cmd_reject <= 1'b1;
                end else if (hit) begin
                  cmd_reject <= 1'b1;
                  if (opc_r == `SFEP_OPC_HALF) begin
                    write_permit_latch <= 1'b0;
                  end
                end else begin
                  st_r <= ST_WIPE;
                  busy_flag <= 1'b1;
                  wipe_req <= 1'b1;
                  if (opc_r == `SFEP_OPC_SMALL) begin
                    wipe_kind <= `SFEP_KIND_SMALL;
                    wipe_addr <= addr_r & `SFEP_SMALL_MASK;
                    tmr_r <= SMALL_WIPE_CYC;
                  end else if (opc_r == `SFEP_OPC_HALF) begin
                    wipe_kind <= `SFEP_KIND_HALF;
                    wipe_addr <= addr_r & `SFEP_HALF_MASK;
                    tmr_r <= HALF_WIPE_CYC;
                  end else begin
                    wipe_kind <= `SFEP_KIND_MID;
                    wipe_addr <= addr_r & `SFEP_MID_MASK;
                    tmr_r <= MID_WIPE_CYC;
                  end
                end
              end
              `SFEP_OPC_WHOLE_A, `SFEP_OPC_WHOLE_B: begin
                if (aligned & (byte_cnt_r == `SFEP_CMD_BYTES) & permit_ok &
                    (protect_range_bits[2:0] == 3'h0)) begin
                  st_r <= ST_WIPE;
                  busy_flag <= 1'b1;
                  wipe_req <= 1'b1;
                  wipe_kind <= `SFEP_KIND_WHOLE;
                  wipe_addr <= 24'h000000;
                  tmr_r <= WHOLE_WIPE_CYC;
                end else begin
                  cmd_reject <= 1'b1;
                end
              end
              `SFEP_OPC_PAGE, `SFEP_OPC_QPAGE: begin
                if (aligned & (byte_cnt_r >= `SFEP_PAGE_MIN_BYTES) &
                    permit_ok & ~hit &
                    (opc_r == `SFEP_OPC_PAGE | four_lane_allow)) begin
                  st_r <= ST_PUSH;
                  busy_flag <= 1'b1;
                  walk_r <= 9'h000;
                  page_base_r <= {addr_r[23:8], 8'h00};
                  tmr_r <= PAGE_WRITE_CYC;
                end else begin
                  cmd_reject <= 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_WIPE: begin
          if (tmr_r <= 32'h1) begin
            st_r <= ST_IDLE;
            busy_flag <= 1'b0;
            write_permit_latch <= 1'b0;
          end else begin
            tmr_r <= tmr_r - 32'h1;
          end
        end
        ST_PUSH: begin
          if (tmr_r > 32'h1) begin
            tmr_r <= tmr_r - 32'h1;
          end
          if (walk_r[8]) begin
            st_r <= ST_PROG;
          end else if (!pvld_r[walk_r[7:0]] || fifo_in_ready) begin
            walk_r <= walk_r + 9'h001;
          end
        end
        ST_PROG: begin
          if (tmr_r > 32'h1) begin
            tmr_r <= tmr_r - 32'h1;
          end else if (!prog_valid) begin
            st_r <= ST_IDLE;
            busy_flag <= 1'b0;
            write_permit_latch <= 1'b0;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // program stream to the array
  // ****************************************************************
  assign fifo_in_valid = (st_r == ST_PUSH) & ~walk_r[8] &
    pvld_r[walk_r[7:0]];

  sfep_fifo #(
    .W(`SFEP_FIFO_W),
    .D(`SFEP_FIFO_D),
    .AW(`SFEP_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({walk_r[7:0], pbuf[walk_r[7:0]]}),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(fifo_out_data)
  );

  assign prog_addr = {page_base_r[23:8], fifo_out_data[15:8]};
  assign prog_data = fifo_out_data[7:0];
endmodule
`default_nettype wire

// File: sim/sfep_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// erase / program sequencer checker
// ****************************************
module sfep_chk #(
  parameter [31:0] SMALL_WIPE_CYC = 32'h1,
  parameter [31:0] HALF_WIPE_CYC = 32'h1,
  parameter [31:0] MID_WIPE_CYC = 32'h1,
  parameter [31:0] WHOLE_WIPE_CYC = 32'h1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic prog_ready,
  input wire logic busy_flag,
  input wire logic write_permit_latch,
  input wire logic wipe_req,
  input wire logic [1:0] wipe_kind,
  input wire logic [23:0] wipe_addr,
  input wire logic prog_valid,
  input wire logic [23:0] prog_addr,
  input wire logic [7:0] prog_data,
  input wire logic cmd_reject
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [31:0] cnt_r;
  logic [1:0] kind_r;
  logic wipe_r;
  wire [31:0] need;
  assign need = kind_r == 2'h0 ? SMALL_WIPE_CYC :
                kind_r == 2'h1 ? HALF_WIPE_CYC :
                kind_r == 2'h2 ? MID_WIPE_CYC : WHOLE_WIPE_CYC;
  // busy length of the running wipe
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 32'h0;
      kind_r <= 2'h0;
      wipe_r <= 1'b0;
    end else begin
      cnt_r <= busy_flag ? cnt_r + 32'h1 : 32'h0;
      if ($rose(busy_flag)) begin
        wipe_r <= wipe_req;
        kind_r <= wipe_kind;
      end
    end
  end
  sequence s_start; wipe_req && busy_flag; endsequence
  sequence s_run; busy_flag [*8]; endsequence
  sequence s_idle2; !busy_flag ##1 !busy_flag; endsequence
  property p_wipe_permit; wipe_req |-> write_permit_latch; endproperty
  a_wipe_permit: assert property (p_wipe_permit) else $error("wipe without permit");
  property p_small_align; wipe_req && wipe_kind == 2'h0 |-> wipe_addr[11:0] == 12'h0; endproperty
  a_small_align: assert property (p_small_align) else $error("4K base misaligned");
  property p_half_align; wipe_req && wipe_kind == 2'h1 |-> wipe_addr[14:0] == 15'h0; endproperty
  a_half_align: assert property (p_half_align) else $error("32K base misaligned");
  property p_mid_align; wipe_req && wipe_kind == 2'h2 |-> wipe_addr[15:0] == 16'h0; endproperty
  a_mid_align: assert property (p_mid_align) else $error("64K base misaligned");
  property p_whole_addr; wipe_req && wipe_kind == 2'h3 |-> wipe_addr == 24'h0; endproperty
  a_whole_addr: assert property (p_whole_addr) else $error("whole wipe base nonzero");
  property p_wipe_run; s_start |-> s_run; endproperty
  a_wipe_run: assert property (p_wipe_run) else $error("wipe busy too short");
  property p_reject_idle; cmd_reject |-> s_idle2; endproperty
  a_reject_idle: assert property (p_reject_idle) else $error("busy after reject");
  property p_busy_quiet; $past(busy_flag) && busy_flag |-> !wipe_req && !cmd_reject; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("command taken while busy");
  property p_end_latch; $fell(busy_flag) |-> !write_permit_latch; endproperty
  a_end_latch: assert property (p_end_latch) else $error("latch kept after op");
  property p_wipe_time; $fell(busy_flag) && wipe_r |-> cnt_r >= need - 32'h1; endproperty
  a_wipe_time: assert property (p_wipe_time) else $error("wipe ended early");
  property p_prog_busy; prog_valid |-> busy_flag; endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("program word while idle");
  property p_prog_hold;
    prog_valid && !prog_ready |=> prog_valid && $stable(prog_addr) && $stable(prog_data);
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("program word dropped");
endmodule
bind sfep_top sfep_chk #(.SMALL_WIPE_CYC(SMALL_WIPE_CYC),
  .HALF_WIPE_CYC(HALF_WIPE_CYC), .MID_WIPE_CYC(MID_WIPE_CYC),
  .WHOLE_WIPE_CYC(WHOLE_WIPE_CYC)) sfep_chk_inst (.clk(clk),
  .sys_rst(sys_rst), .prog_ready(prog_ready), .busy_flag(busy_flag),
  .write_permit_latch(write_permit_latch), .wipe_req(wipe_req),
  .wipe_kind(wipe_kind), .wipe_addr(wipe_addr), .prog_valid(prog_valid),
  .prog_addr(prog_addr), .prog_data(prog_data), .cmd_reject(cmd_reject));
`default_nettype wire

// File: sim/sfep_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host link driver, mode 0 or 3, 125 ns clock
// ****************************************
module sfep_host (
  output logic chip_select_n,
  output logic serial_clk,
  output logic [3:0] io_lane_in
);
  localparam realtime HALF = 62.5;
  logic mode3;
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    io_lane_in = 4'h5;
    mode3 = 1'b0;
  end
  // idle level set while deselected, clock still outside frames
  task sel;
    serial_clk = mode3;
    #HALF;
    chip_select_n = 1'b0;
    #HALF;
  endtask
  task shift(input [3:0] v);
    serial_clk = 1'b0;
    io_lane_in = v;
    #HALF;
    serial_clk = 1'b1;
    #HALF;
  endtask
  // single lane: upper lanes toggle as noise
  task send(input [7:0] b, input int nb, input bit quad);
    if (quad) begin
      shift(b[7:4]);
      shift(b[3:0]);
    end else
      for (int i = 7; i > 7 - nb; i--)
        shift({~io_lane_in[3:1], b[i]});
  endtask
  task desel;
    serial_clk = mode3;
    #HALF;
    chip_select_n = 1'b1;
    io_lane_in = ~io_lane_in;
    #(2 * HALF);
  endtask
endmodule
`default_nettype wire

// File: sim/sfep_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
// ****************************************
// sequencer bench
// ****************************************
module sfep_top_tb;
  localparam [33:0] REJ = {2'h2, 32'h0};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] protect_range_bits = 5'h0;
  logic four_lane_allow = 1'b0;
  logic prog_ready = 1'b0;
  logic hold_off = 1'b0;
  wire chip_select_n, serial_clk, busy_flag, write_permit_latch;
  wire wipe_req, prog_valid, cmd_reject;
  wire [3:0] io_lane_in;
  wire [1:0] wipe_kind;
  wire [23:0] wipe_addr, prog_addr;
  wire [7:0] prog_data;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [33:0] notes[$];
  logic [31:0] lfsr = 32'h63a4;
  logic [31:0] dseed = 32'h63a4;
  logic [7:0] pg[256];
  bit wr[256];
  sfep_host sfep_host_inst (.chip_select_n(chip_select_n),
    .serial_clk(serial_clk), .io_lane_in(io_lane_in));
  sfep_top #(.SMALL_WIPE_CYC(32'h3c), .HALF_WIPE_CYC(32'h9c4),
    .MID_WIPE_CYC(32'h50), .WHOLE_WIPE_CYC(32'h64),
    .PAGE_WRITE_CYC(32'h28)) sfep_top_inst (.clk(clk), .sys_rst(sys_rst),
    .chip_select_n(chip_select_n), .serial_clk(serial_clk),
    .io_lane_in(io_lane_in), .protect_range_bits(protect_range_bits),
    .four_lane_allow(four_lane_allow), .prog_ready(prog_ready),
    .busy_flag(busy_flag), .write_permit_latch(write_permit_latch),
    .wipe_req(wipe_req), .wipe_kind(wipe_kind), .wipe_addr(wipe_addr),
    .prog_valid(prog_valid), .prog_addr(prog_addr),
    .prog_data(prog_data), .cmd_reject(cmd_reject));
  initial forever #2.5 clk = ~clk;
  function automatic [31:0] lfsr_next(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [33:0] wp(input [1:0] k, input [23:0] a);
    return {2'h1, 6'h0, k, a};
  endfunction
  task test_done;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // random back-pressure on the program port, plus the hang limit
  always @(posedge clk) begin
    #1;
    lfsr = lfsr_next(lfsr);
    prog_ready = !hold_off && lfsr[1:0] != 2'h0;
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      test_done();
    end
  end
  task take(input [33:0] got);
    logic [33:0] exp;
    exp = notes.size() > 0 ? notes.pop_front() : 34'h0;
    `CHK(got, exp)
  endtask
  always @(posedge clk) if (!sys_rst) begin
    if (wipe_req) take({2'h1, 6'h0, wipe_kind, wipe_addr});
    if (cmd_reject) take(REJ);
    if (prog_valid && prog_ready) take({2'h3, prog_addr, prog_data});
  end
  task op(input [7:0] opc, input [23:0] a, input int nab, input int nbits,
          input [33:0] exp);
    sfep_host_inst.sel();
    sfep_host_inst.send(opc, 8, 1'b0);
    for (int i = 2; i > 2 - nab; i--) sfep_host_inst.send(a[8*i+:8], 8, 1'b0);
    if (nbits > 0) sfep_host_inst.send(a[7:0], nbits, 1'b0);
    if (exp !== 34'h0) notes.push_back(exp);
    sfep_host_inst.desel();
  endtask
  task pw(input [7:0] opc, input [23:0] a, input int n, input bit ok);
    logic [7:0] off;
    wr = '{default: 1'b0};
    sfep_host_inst.sel();
    sfep_host_inst.send(opc, 8, 1'b0);
    for (int i = 2; i >= 0; i--) sfep_host_inst.send(a[8*i+:8], 8, 1'b0);
    for (int k = 0; k < n; k++) begin
      dseed = lfsr_next(dseed);
      off = a[7:0] + k[7:0];
      pg[off] = dseed[7:0];
      wr[off] = 1'b1;
      sfep_host_inst.send(dseed[7:0], 8, opc == 8'h32);
    end
    if (!ok) notes.push_back(REJ);
    for (int o = 0; o < 256; o++)
      if (ok && wr[o]) notes.push_back({2'h3, a[23:8], o[7:0], pg[o]});
    sfep_host_inst.desel();
  endtask
  task settle(input string s);
    for (int i = 0; i < 4000 && busy_flag !== 1'b0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    $display("end of test %s", s);
  endtask
  task permit;
    op(8'h06, 24'h0, 0, 0, 34'h0);
    `CHK(write_permit_latch, 1'b1)
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    `CHK({busy_flag, write_permit_latch, prog_valid}, 3'h0)
    op(8'h20, 24'h123456, 3, 0, REJ);
    settle("wipe without permit");
    permit();
    op(8'h20, 24'h123456, 3, 0, wp(2'h0, 24'h123000));
    `CHK(busy_flag, 1'b1)
    settle("small wipe");
    `CHK(write_permit_latch, 1'b0)
    permit();
    op(8'h20, 24'h123456, 2, 4, REJ);
    `CHK(write_permit_latch, 1'b1)
    sfep_host_inst.mode3 = 1'b1;
    op(8'h52, 24'h3fffff, 3, 0, wp(2'h1, 24'h3f8000));
    `CHK(busy_flag, 1'b1)
    op(8'hd8, 24'h010000, 3, 0, 34'h0);
    `CHK(busy_flag, 1'b1)
    settle("half wipe, busy ignore");
    sfep_host_inst.mode3 = 1'b0;
    @(posedge clk) #1 protect_range_bits = 5'h01;
    permit();
    op(8'h52, 24'hff8123, 3, 0, REJ);
    `CHK(write_permit_latch, 1'b0)
    permit();
    op(8'hd8, 24'hff0000, 3, 0, REJ);
    op(8'h20, 24'hfff000, 3, 0, REJ);
    pw(8'h02, 24'hff0000, 1, 1'b0);
    `CHK(write_permit_latch, 1'b1)
    op(8'hc7, 24'h0, 0, 0, REJ);
    permit();
    op(8'hd8, 24'h7e1234, 3, 0, wp(2'h2, 24'h7e0000));
    settle("protection");
    @(posedge clk) #1 protect_range_bits = 5'h09;
    permit();
    op(8'h20, 24'h00f123, 3, 0, REJ);
    op(8'h20, 24'h010123, 3, 0, wp(2'h0, 24'h010000));
    settle("bottom protection");
    @(posedge clk) #1 protect_range_bits = 5'h00;
    for (int i = 0; i < 2; i++) begin
      permit();
      op(i ? 8'hc7 : 8'h60, 24'h0, 0, 0, wp(2'h3, 24'h0));
      settle("whole wipe");
    end
    permit();
    pw(8'h02, 24'h0012f0, 0, 1'b0);
    `CHK(write_permit_latch, 1'b1)
    pw(8'h02, 24'h0012f0, 20, 1'b1);
    settle("wrapping page");
    `CHK(write_permit_latch, 1'b0)
    pw(8'h02, 24'h002200, 2, 1'b0);
    permit();
    pw(8'h32, 24'h004500, 1, 1'b0);
    permit();
    @(posedge clk) #1 four_lane_allow = 1'b1;
    hold_off = 1'b1;
    pw(8'h32, 24'h004500, 260, 1'b1);
    repeat (200) @(posedge clk);
    hold_off = 1'b0;
    settle("quad page, full buffer");
    `CHK(32'(notes.size()), 32'h0)
    test_done();
  end
endmodule
`default_nettype wire
